/* verilog/pri_pkg.sv */
// shared constants and types of the priority interrupt controller
package pri_pkg;

  // sizes
  localparam int unsigned NUM_SRC      = 8;
  localparam int unsigned NUM_TRAP     = 2;
  localparam int unsigned NUM_CAND     = NUM_SRC + NUM_TRAP;
  localparam int unsigned NUM_PRIO_REG = 5;
  localparam int unsigned STACK_DEPTH  = 16;
  localparam int unsigned STACK_CNT_W  = 5;
  localparam int unsigned TIMED_DISABLE_INSTR_W       = 14;

  // byte addresses on the register bus
  localparam logic [7:0] ADR_PRIO_TWOWIRE = 8'h00;
  localparam logic [7:0] ADR_PRIO_CALENDAR = 8'h04;
  localparam logic [7:0] ADR_PRIO_ERRORS  = 8'h08;
  localparam logic [7:0] ADR_PRIO_LOWVOLT = 8'h0c;
  localparam logic [7:0] ADR_PRIO_CHARGE  = 8'h10;
  localparam logic [7:0] ADR_STATUS       = 8'h14;
  localparam logic [7:0] ADR_FLAG         = 8'h18;
  localparam logic [7:0] ADR_ENABLE       = 8'h1c;
  localparam logic [7:0] ADR_CONTROL      = 8'h20;
  localparam logic [7:0] PRIO_ADR [NUM_PRIO_REG] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};

  // priority registers: implemented bits and values after reset (level 4)
  localparam logic [15:0] PRIO_WMASK [NUM_PRIO_REG] = '{16'h0770, 16'h0700, 16'h7770,
                                                        16'h0007, 16'h0070};
  localparam logic [15:0] PRIO_RST   [NUM_PRIO_REG] = '{16'h0440, 16'h0400, 16'h4440,
                                                        16'h0004, 16'h0040};

  // sources: 0 bus master, 1 bus slave, 2 calendar, 3 checksum error,
  // 4 serial two error, 5 serial one error, 6 low voltage, 7 charge measure
  localparam int SRC_REG [NUM_SRC] = '{0, 0, 1, 2, 2, 2, 3, 4};
  localparam int SRC_LSB [NUM_SRC] = '{8, 4, 8, 12, 8, 4, 0, 4};
  // vector identifiers are arbitrary
  localparam logic [6:0] SRC_VEC [NUM_SRC] = '{7'h26, 7'h25, 7'h3e, 7'h43,
                                               7'h42, 7'h41, 7'h48, 7'h4e};
  localparam logic [3:0] TRAP_LEVEL [NUM_TRAP] = '{4'he, 4'hd};
  localparam logic [6:0] TRAP_VEC   [NUM_TRAP] = '{7'h02, 7'h03};
  localparam logic [3:0] USER_TOP_LEVEL = 4'h7;

  // status and control field positions
  localparam int STAT_UNACKED_BIT  = 15;
  localparam int STAT_CAPTURE_BIT  = 13;
  localparam int STAT_LEVEL_LSB    = 8;
  localparam int STAT_VEC_LSB      = 0;
  localparam int CTRL_NEST_DIS_BIT = 15;
  localparam int CTRL_TRAP_LSB     = 0;

  typedef struct packed {
    logic [3:0] level;
    logic [6:0] vec;
  } pri_cand_type;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pri_wb_req_type;

  typedef struct packed {
    logic       req;
    logic [3:0] level;
    logic [6:0] vec;
  } pri_cpu_req_type;

  typedef struct packed {
    logic              ack;
    logic              ret;
    logic              level_wr;
    logic [3:0]        level;
    logic              timed_disable_instr;
    logic [TIMED_DISABLE_INSTR_W-1:0] timed_disable_instr_len;
  } pri_cpu_cmd_type;

endpackage

/* verilog/pri_arbiter.sv */
// picks the highest level candidate, lowest vector on a tie
`timescale 1ns/1ps
`default_nettype none
module pri_arbiter (
  input  wire pri_pkg::pri_cand_type [pri_pkg::NUM_CAND-1:0] cand_i,
  output var  pri_pkg::pri_cand_type                          best_o
);

  // level zero means no candidate; strict compare keeps lowest vector on ties
  always_comb begin
    best_o = '0;
    for (int i = 0; i < pri_pkg::NUM_CAND; i++) begin
      if (cand_i[i].level > best_o.level ||
          (cand_i[i].level != 4'h0 && cand_i[i].level == best_o.level &&
           cand_i[i].vec < best_o.vec)) begin
        best_o = cand_i[i];
      end
    end
  end

endmodule // pri_arbiter
`default_nettype wire

/* verilog/pri_level_stack.sv */
// stack of cpu levels saved on interrupt entry
`timescale 1ns/1ps
`default_nettype none
module pri_level_stack (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       push_i,
  input  wire logic       pop_i,
  input  wire logic [3:0] level_i,
  output logic [3:0]      top_o,
  output logic            nonempty_o
);

  typedef struct packed {
    logic [pri_pkg::STACK_DEPTH-1:0][3:0] mem;
    logic [pri_pkg::STACK_CNT_W-1:0]      count;
  } pri_stack_type;

  pri_stack_type s;
  pri_stack_type next_s;

  // levels only rise on entry, so sixteen slots never overflow
  always_comb begin
    next_s = s;
    if (push_i && s.count < 5'(pri_pkg::STACK_DEPTH)) begin
      next_s.mem[s.count[3:0]] = level_i;
      next_s.count = s.count + 5'h01;
    end else if (pop_i && s.count != 5'h00) begin
      next_s.count = s.count - 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // empty stack hands back level zero
  assign top_o      = (s.count == 5'h00) ? 4'h0 : s.mem[4'(s.count - 5'h01)];
  assign nonempty_o = (s.count != 5'h00);

endmodule // pri_level_stack
`default_nettype wire

/* verilog/pri_controller.sv */
// priority interrupt controller with wishbone register slave
//
// Notes on behaviour
// - three-bit priority per source; zero disables the source entirely.
// - reset loads every source priority field with level four.
// - unimplemented bits of priority and status registers read zero, ignore writes.
// - bus master priority bits 10-8, bus slave bits 6-4.
// - calendar priority at bits 10-8, rest unimplemented.
// - checksum error 14-12, serial two error 10-8, serial one error 6-4.
// - low voltage priority at bits 2-0, bits 15-3 unimplemented.
// - charge measure priority at bits 6-4, other bits unimplemented.
// - status bit 15 set while the best pending request waits at or below cpu level.
// - capture bit 13 picks pending best or last acknowledged vector.
// - status bits 11-8 show the cpu level in binary.
// - status bits 6-0 show vector id, vector number is id plus 8.
// - only enabled sources request; flags stay set until software clears.
// - flag still set at return gives an immediate new request.
// - return restores the level saved on entry.
// - a trap re-requests after return until its flag is cleared.
// - cpu level 7 masks all user sources; a trap passes whenever its level is above cpu level.
// - timed disable blocks levels 1-6, level 7 still interrupts.
// - nesting disable stops user nesting inside a service routine.
// - a request is taken only above the current cpu level.
`timescale 1ns/1ps
`default_nettype none
module pri_controller (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  input  wire pri_pkg::pri_wb_req_type           wb_i,
  output logic                                   wb_ack_o,
  output logic [31:0]                            wb_dat_o,
  input  wire logic [pri_pkg::NUM_SRC-1:0]       src_evt_i,
  input  wire logic [pri_pkg::NUM_TRAP-1:0]      trap_evt_i,
  input  wire pri_pkg::pri_cpu_cmd_type          cpu_i,
  output var  pri_pkg::pri_cpu_req_type          irq_o,
  output logic [3:0]                             cpu_level_o,
  output logic                                   in_service_o
);

  typedef struct packed {
    logic [pri_pkg::NUM_PRIO_REG-1:0][15:0] prio;
    logic [pri_pkg::NUM_SRC-1:0]            flag;
    logic [pri_pkg::NUM_SRC-1:0]            enable;
    logic                                   nest_dis;
    logic [pri_pkg::NUM_TRAP-1:0]           trap_flag;
    logic                                   capture;
    logic [3:0]                             cpu_level;
    logic [6:0]                             acked_vec;
    logic [pri_pkg::TIMED_DISABLE_INSTR_W-1:0]             timed_disable_instr_cnt;
    pri_pkg::pri_cpu_req_type               irq;
    logic                                   unacked;
    logic [6:0]                             shown_vec;
    logic                                   in_isr;
    logic                                   wb_ack;
    logic [31:0]                            wb_dat;
  } pri_state_type;

  localparam pri_state_type STATE_RST = '{
    prio: {pri_pkg::PRIO_RST[4], pri_pkg::PRIO_RST[3], pri_pkg::PRIO_RST[2],
           pri_pkg::PRIO_RST[1], pri_pkg::PRIO_RST[0]},
    default: '0
  };

  pri_state_type s;
  pri_state_type next_s;

  // byte lanes 0 and 1 carry the 16-bit registers
  function automatic logic [15:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [2:0] field_of(input logic [15:0] r, input int lsb);
    field_of = r[lsb +: 3];
  endfunction

  // bus decode; a request is answered once, ack drops the cycle after
  logic        bus_req;
  logic        bus_wr;
  logic [15:0] wmask;
  assign bus_req = wb_i.cyc && wb_i.stb && !s.wb_ack;
  assign bus_wr  = bus_req && wb_i.we;
  assign wmask   = lane_mask(wb_i.sel);

  // level stack
  logic       push;
  logic       pop;
  logic [3:0] stack_top;
  logic       stack_nonempty;
  assign push = cpu_i.ack && s.irq.req;
  assign pop  = cpu_i.ret && !push;

  pri_level_stack u_stack (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .push_i     (push),
    .pop_i      (pop),
    .level_i    (s.cpu_level),
    .top_o      (stack_top),
    .nonempty_o (stack_nonempty)
  );

  // masking conditions for user sources
  logic timed_disable_instr_active;
  logic nest_block;
  assign timed_disable_instr_active = (s.timed_disable_instr_cnt != '0);
  assign nest_block  = s.nest_dis && s.in_isr;

  wire pri_pkg::pri_cand_type [pri_pkg::NUM_CAND-1:0] pend_cand;
  wire pri_pkg::pri_cand_type [pri_pkg::NUM_CAND-1:0] allow_cand;
  pri_pkg::pri_cand_type pend_best;
  pri_pkg::pri_cand_type allow_best;

  // user candidates: flag and enable and nonzero priority
  for (genvar g = 0; g < pri_pkg::NUM_SRC; g++) begin : g_src
    logic [2:0] p;
    logic       ok;
    assign p = field_of(s.prio[pri_pkg::SRC_REG[g]], pri_pkg::SRC_LSB[g]);
    assign pend_cand[g] = '{level: (s.flag[g] && s.enable[g]) ? {1'b0, p} : 4'h0,
                            vec: pri_pkg::SRC_VEC[g]};
    assign ok = (pend_cand[g].level > s.cpu_level) && !nest_block &&
                !(timed_disable_instr_active && pend_cand[g].level < pri_pkg::USER_TOP_LEVEL);
    assign allow_cand[g] = '{level: ok ? pend_cand[g].level : 4'h0,
                             vec: pri_pkg::SRC_VEC[g]};
  end

  // trap candidates ignore every user mask
  for (genvar t = 0; t < pri_pkg::NUM_TRAP; t++) begin : g_trap
    localparam int unsigned K = pri_pkg::NUM_SRC + t;
    assign pend_cand[K] = '{level: s.trap_flag[t] ? pri_pkg::TRAP_LEVEL[t] : 4'h0,
                            vec: pri_pkg::TRAP_VEC[t]};
    assign allow_cand[K] = '{level: (pend_cand[K].level > s.cpu_level) ?
                                    pend_cand[K].level : 4'h0,
                             vec: pri_pkg::TRAP_VEC[t]};
  end

  pri_arbiter u_pend_arb (
    .cand_i (pend_cand),
    .best_o (pend_best)
  );

  pri_arbiter u_allow_arb (
    .cand_i (allow_cand),
    .best_o (allow_best)
  );

  // register read mux; unmapped addresses read zero
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    for (int k = 0; k < pri_pkg::NUM_PRIO_REG; k++) begin
      if (wb_i.adr == pri_pkg::PRIO_ADR[k]) begin
        rd_word = s.prio[k] & pri_pkg::PRIO_WMASK[k];
      end
    end
    case (wb_i.adr)
      pri_pkg::ADR_STATUS: begin
        rd_word[pri_pkg::STAT_UNACKED_BIT]     = s.unacked;
        rd_word[pri_pkg::STAT_CAPTURE_BIT]     = s.capture;
        rd_word[pri_pkg::STAT_LEVEL_LSB +: 4]  = s.cpu_level;
        rd_word[pri_pkg::STAT_VEC_LSB +: 7]    = s.shown_vec;
      end
      pri_pkg::ADR_FLAG:    rd_word[7:0] = s.flag;
      pri_pkg::ADR_ENABLE:  rd_word[7:0] = s.enable;
      pri_pkg::ADR_CONTROL: begin
        rd_word[pri_pkg::CTRL_NEST_DIS_BIT]                    = s.nest_dis;
        rd_word[pri_pkg::CTRL_TRAP_LSB +: pri_pkg::NUM_TRAP]   = s.trap_flag;
      end
      default: ;
    endcase
  end

  // next state: bus writes, flags, cpu handshake, request choice
  logic [pri_pkg::NUM_SRC-1:0]  flag_clr;
  logic [pri_pkg::NUM_TRAP-1:0] trap_clr;
  always_comb begin
    next_s   = s;
    flag_clr = '0;
    trap_clr = '0;
    // register bus answer, one cycle after the strobe
    next_s.wb_ack = bus_req;
    next_s.wb_dat = (bus_req && !wb_i.we) ? {16'h0000, rd_word} : 32'h0000_0000;
    if (bus_wr) begin
      for (int k = 0; k < pri_pkg::NUM_PRIO_REG; k++) begin
        if (wb_i.adr == pri_pkg::PRIO_ADR[k]) begin
          next_s.prio[k] = (s.prio[k] & ~(wmask & pri_pkg::PRIO_WMASK[k])) |
                           (wb_i.dat[15:0] & wmask & pri_pkg::PRIO_WMASK[k]);
        end
      end
      case (wb_i.adr)
        pri_pkg::ADR_STATUS: begin
          if (wmask[pri_pkg::STAT_CAPTURE_BIT]) begin
            next_s.capture = wb_i.dat[pri_pkg::STAT_CAPTURE_BIT];
          end
        end
        pri_pkg::ADR_FLAG:   flag_clr = wb_i.dat[7:0] & wmask[7:0];
        pri_pkg::ADR_ENABLE: begin
          if (wmask[0]) begin
            next_s.enable = wb_i.dat[7:0];
          end
        end
        pri_pkg::ADR_CONTROL: begin
          if (wmask[pri_pkg::CTRL_NEST_DIS_BIT]) begin
            next_s.nest_dis = wb_i.dat[pri_pkg::CTRL_NEST_DIS_BIT];
          end
          trap_clr = wb_i.dat[pri_pkg::CTRL_TRAP_LSB +: pri_pkg::NUM_TRAP] &
                     wmask[pri_pkg::CTRL_TRAP_LSB +: pri_pkg::NUM_TRAP];
        end
        default: ;
      endcase
    end
    // sticky flags: a new event beats a clear in the same cycle
    next_s.flag      = (s.flag & ~flag_clr) | src_evt_i;
    next_s.trap_flag = (s.trap_flag & ~trap_clr) | trap_evt_i;
    // acknowledge beats return, return beats a direct level write
    if (push) begin
      next_s.cpu_level = s.irq.level;
      next_s.acked_vec = s.irq.vec;
      next_s.in_isr    = 1'b1;
    end else if (pop) begin
      next_s.cpu_level = stack_top;
      next_s.in_isr    = (stack_top != 4'h0) || (s.cpu_level > stack_top && stack_nonempty &&
                                                 !(stack_top == 4'h0));
    end else if (cpu_i.level_wr) begin
      next_s.cpu_level = cpu_i.level;
    end
    // timed disable counter
    if (cpu_i.timed_disable_instr) begin
      next_s.timed_disable_instr_cnt = cpu_i.timed_disable_instr_len;
    end else if (timed_disable_instr_active) begin
      next_s.timed_disable_instr_cnt = s.timed_disable_instr_cnt - 14'h0001;
    end
    // request drops at once after an acknowledge; a still-set flag comes
    // back as soon as the restored level lets it through
    next_s.irq.req   = (allow_best.level != 4'h0) && !push;
    next_s.irq.level = allow_best.level;
    next_s.irq.vec   = allow_best.vec;
    next_s.unacked   = (pend_best.level != 4'h0) && (pend_best.level <= s.cpu_level);
    next_s.shown_vec = s.capture ? pend_best.vec : s.acked_vec;
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= STATE_RST;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign wb_ack_o     = s.wb_ack;
  assign wb_dat_o     = s.wb_dat;
  assign irq_o        = s.irq;
  assign cpu_level_o  = s.cpu_level;
  assign in_service_o = s.in_isr;

  // checks; they pause while the clock enable is low and during reset,
  // apart from the two that carry a reset term of their own
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  reset_level_a: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> (s.prio[0] == 16'h0440 && s.prio[2] == 16'h4440 && s.prio[3] == 16'h0004))
    else $error("priority fields not at level four after reset");

  zero_prio_a: assert property (
    (irq_o.req && irq_o.vec == pri_pkg::SRC_VEC[6]) |-> $past(s.prio[3][2:0]) != 3'h0)
    else $error("request from a source without level");

  reserved_zero_a: assert property (
    (bus_req && !wb_i.we && wb_i.adr == pri_pkg::ADR_PRIO_ERRORS) |=>
      (wb_dat_o[31:0] & 32'hffff_888f) == 32'h0000_0000)
    else $error("unimplemented priority bits read nonzero");

  field_pos_a: assert property (
    (bus_wr && wb_i.adr == pri_pkg::ADR_PRIO_TWOWIRE && wb_i.sel[1:0] == 2'b11) |=>
      field_of(s.prio[0], 8) == $past(wb_i.dat[10:8]))
    else $error("bus master field not written at bits 10-8");

  unacked_flag_a: assert property (
    (pend_best.level != 4'h0 && pend_best.level <= s.cpu_level) |=> s.unacked)
    else $error("waiting request not reported");

  capture_sel_a: assert property (
    (s.capture && pend_best.level != 4'h0) |=> s.shown_vec == $past(pend_best.vec))
    else $error("vector field not following pending best");

  ack_level_a: assert property (
    (cpu_i.ack && irq_o.req) |=> (cpu_level_o == $past(irq_o.level) && !irq_o.req))
    else $error("acknowledge did not raise cpu level");

  ret_restore_a: assert property (
    (pop && !push) |=> cpu_level_o == $past(stack_top))
    else $error("return did not restore saved level");

  timed_disable_instr_block_a: assert property (
    (timed_disable_instr_active && allow_best.level != 4'h0) |-> allow_best.level >= 4'h7)
    else $error("timed disable let a low level through");

  nest_block_a: assert property (
    (nest_block && allow_best.level != 4'h0) |-> allow_best.level > 4'h7)
    else $error("user source nested while nesting disabled");

  wb_answer_a: assert property (
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");

  status_read_a: assert property (
    (bus_req && !wb_i.we && wb_i.adr == pri_pkg::ADR_STATUS) |=>
      (wb_dat_o[11:8] == $past(s.cpu_level) && (wb_dat_o & 32'hffff_5080) == 32'h0000_0000))
    else $error("status read shows a wrong level or a set unused bit");

  // traps bypass the user masks, so the allowed winner never sits below a trap
  trap_pass_a: assert property (
    (pend_cand[pri_pkg::NUM_SRC].level > s.cpu_level) |->
      allow_best.level >= pend_cand[pri_pkg::NUM_SRC].level)
    else $error("trap held back below its level");

  // a request may only name a source whose flag and enable were both set
  for (genvar g = 0; g < pri_pkg::NUM_SRC; g++) begin : g_src_chk
    src_gate_a: assert property (
      (irq_o.req && irq_o.vec == pri_pkg::SRC_VEC[g]) |-> $past(s.flag[g] && s.enable[g]))
      else $error("request from a source without flag and enable");
  end

  // own reset term: the default one would switch this check off exactly when it matters
  ce_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> s == $past(s))
    else $error("state moved while the clock enable was low");

  // scenarios the bench is meant to reach
  ack_taken_c:  cover property (cpu_i.ack && irq_o.req ##[1:20] pop);
  reentry_c:    cover property (pop ##1 irq_o.req);
  timed_disable_instr_wait_c:  cover property (timed_disable_instr_active && s.unacked);
  trap_nest_c:  cover property (nest_block && allow_best.level > 4'h7);
  freeze_c:     cover property (@(posedge clk_i) disable iff (rst_i) !ce_i && src_evt_i != '0);

endmodule // pri_controller
`default_nettype wire

/* dv/pri_cpu_model.sv */
// behavioural processor core that takes requests and returns from routines
`timescale 1ns/1ps
`default_nettype none
module pri_cpu_model (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     auto_i,  // take requests on its own
  input  wire logic [7:0]               wait_i,  // cycles of request before taking it
  input  wire logic [7:0]               svc_i,   // cycles spent in a routine
  input  wire pri_pkg::pri_cpu_cmd_type cmd_i,   // level writes and timed disable from bench
  input  wire pri_pkg::pri_cpu_req_type irq_i,
  output pri_pkg::pri_cpu_cmd_type      cpu_o
);
  logic       ack_q;
  logic       ret_q;
  logic       busy;
  logic [7:0] cnt;

  // own take and return pulses ride on top of the bench's commands
  always_comb begin
    cpu_o     = cmd_i;
    cpu_o.ack = ack_q;
    cpu_o.ret = ret_q;
  end

  // one routine at a time: this core never nests, which keeps the model small
  always_ff @(posedge clk_i) begin
    ack_q <= 1'b0;
    ret_q <= 1'b0;
    if (rst_i) begin
      busy <= 1'b0;
      cnt  <= 8'h00;
    end else if (!busy) begin
      if (auto_i && irq_i.req && cnt >= wait_i) begin
        ack_q <= 1'b1;
        busy  <= 1'b1;
        cnt   <= 8'h00;
      end else if (auto_i && irq_i.req) begin
        cnt <= cnt + 8'h01;
      end else begin
        cnt <= 8'h00;
      end
    end else if (cnt >= svc_i) begin
      ret_q <= 1'b1;
      busy  <= 1'b0;
      cnt   <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // pri_cpu_model
`default_nettype wire

/* dv/pri_controller_bench.sv */
// self-checking bench of the priority interrupt controller
`timescale 1ns/1ps
`default_nettype none
module pri_controller_bench;
  logic                     clk_i;
  logic                     rst_i;
  logic                     auto;
  logic [7:0]               src_evt;
  logic [1:0]               trap_evt;
  logic                     wb_ack;
  logic [31:0]              wb_dat;
  logic [3:0]               cpu_level;
  logic                     in_service;
  pri_pkg::pri_wb_req_type  wb;
  pri_pkg::pri_cpu_cmd_type cmd;
  pri_pkg::pri_cpu_cmd_type cpu;
  pri_pkg::pri_cpu_req_type irq;
  int                       n_fail;
  int                       n_tests;
  int                       cycles;
  logic [3:0]               lvl;
  logic                     ce;

  pri_controller i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb), .wb_ack_o(wb_ack),
    .wb_dat_o(wb_dat), .src_evt_i(src_evt), .trap_evt_i(trap_evt), .cpu_i(cpu),
    .irq_o(irq), .cpu_level_o(cpu_level), .in_service_o(in_service));
  pri_cpu_model i_cpu (
    .clk_i(clk_i), .rst_i(rst_i), .auto_i(auto), .wait_i(8'h02), .svc_i(8'h14),
    .cmd_i(cmd), .irq_i(irq), .cpu_o(cpu));

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under two thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // classic wishbone cycle: hold everything until ack is sampled, then release
  task automatic wbx(input logic we, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: a, dat: {16'h0000, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    r = wb_dat[15:0];
    wb <= '0;
    if (n >= 50) chk(16'h0000, 16'h0001, "bus ack missing");
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    wbx(1'b1, a, d, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] r;
    wbx(1'b0, a, 16'h0000, r);
    chk(r, e, "register read");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic pulse(input logic [7:0] s, input logic [1:0] t);
    @(posedge clk_i);
    src_evt  <= s;
    trap_evt <= t;
    @(posedge clk_i);
    src_evt  <= 8'h00;
    trap_evt <= 2'b00;
  endtask

  // direct level write or timed disable, one-cycle command pulses
  task automatic cpu_cmd(input logic lw, input logic [3:0] l, input logic di);
    @(posedge clk_i);
    cmd <= '{ack: 1'b0, ret: 1'b0, level_wr: lw, level: l, timed_disable_instr: di, timed_disable_instr_len: 14'd40};
    @(posedge clk_i);
    cmd <= '0;
  endtask

  task automatic wait_level(input logic [3:0] l);
    int n;
    n = 0;
    while (cpu_level !== l && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk({12'h000, cpu_level}, {12'h000, l}, "cpu level");
  endtask

  task automatic req_is(input logic r, input logic [3:0] l, input logic [6:0] v);
    cyc(3);
    if (r) chk({4'h0, irq.req, irq.level, irq.vec}, {4'h0, 1'b1, l, v}, "request");
    else chk({15'h0000, irq.req}, 16'h0000, "no request");
  endtask

  initial begin
    rst_i = 1'b1; auto = 1'b0; src_evt = 8'h00; trap_evt = 2'b00;
    wb = '0; cmd = '0; n_fail = 0; n_tests = 0; cycles = 0; ce = 1'b1;
    cyc(4);
    rst_i <= 1'b0;
    // reset values, implemented bits, read-only and unmapped places
    for (int r = 0; r < pri_pkg::NUM_PRIO_REG; r++) begin
      rchk(pri_pkg::PRIO_ADR[r], pri_pkg::PRIO_RST[r]);
      wr(pri_pkg::PRIO_ADR[r], 16'hffff);
      rchk(pri_pkg::PRIO_ADR[r], pri_pkg::PRIO_WMASK[r]);
      wr(pri_pkg::PRIO_ADR[r], pri_pkg::PRIO_RST[r]);
    end
    rchk(pri_pkg::ADR_STATUS, 16'h0000);
    wr(pri_pkg::ADR_STATUS, 16'hffff);
    rchk(pri_pkg::ADR_STATUS, 16'h2000);
    wr(8'h3c, 16'hffff);
    rchk(8'h3c, 16'h0000);
    $display("test registers done");
    // a flag waits for its enable, then requests
    pulse(8'h01, 2'b00);
    req_is(1'b0, 4'h0, 7'h00);
    wr(pri_pkg::ADR_ENABLE, 16'h00ff);
    req_is(1'b1, 4'h4, pri_pkg::SRC_VEC[0]);
    wr(pri_pkg::ADR_FLAG, 16'h0001);
    // every field position, level zero disables, vector id in status
    for (int i = 0; i < pri_pkg::NUM_SRC; i++) begin
      lvl = 4'((i % 7) + 1);
      wr(pri_pkg::PRIO_ADR[pri_pkg::SRC_REG[i]], 16'h0000);
      pulse(8'h01 << i, 2'b00);
      req_is(1'b0, 4'h0, 7'h00);
      wr(pri_pkg::PRIO_ADR[pri_pkg::SRC_REG[i]], {13'h0000, lvl[2:0]} << pri_pkg::SRC_LSB[i]);
      req_is(1'b1, lvl, pri_pkg::SRC_VEC[i]);
      rchk(pri_pkg::ADR_STATUS, {9'h040, pri_pkg::SRC_VEC[i]});
      wr(pri_pkg::ADR_FLAG, 16'h0001 << i);
      wr(pri_pkg::PRIO_ADR[pri_pkg::SRC_REG[i]], pri_pkg::PRIO_RST[pri_pkg::SRC_REG[i]]);
      req_is(1'b0, 4'h0, 7'h00);
    end
    $display("test fields done");
    pulse(8'h83, 2'b00);
    req_is(1'b1, 4'h4, pri_pkg::SRC_VEC[1]);
    wr(pri_pkg::ADR_FLAG, 16'h00ff);
    $display("test tie done");
    // routine entry, return, re-entry while the flag stays set
    auto <= 1'b1;
    pulse(8'h40, 2'b00);
    wait_level(4'h4);
    chk({15'h0000, in_service}, 16'h0001, "in service");
    wait_level(4'h0);
    wait_level(4'h4);
    wr(pri_pkg::ADR_FLAG, 16'h0040);
    wait_level(4'h0);
    auto <= 1'b0;
    req_is(1'b0, 4'h0, 7'h00);
    wr(pri_pkg::ADR_STATUS, 16'h0000);
    rchk(pri_pkg::ADR_STATUS, {9'h000, pri_pkg::SRC_VEC[6]});
    wr(pri_pkg::ADR_STATUS, 16'h2000);
    $display("test routine done");
    // level 7 masks user sources, traps still pass
    cpu_cmd(1'b1, 4'h7, 1'b0);
    wr(pri_pkg::ADR_PRIO_LOWVOLT, 16'h0007);
    pulse(8'h40, 2'b00);
    req_is(1'b0, 4'h0, 7'h00);
    rchk(pri_pkg::ADR_STATUS, {9'h14e, pri_pkg::SRC_VEC[6]});
    pulse(8'h00, 2'b01);
    req_is(1'b1, pri_pkg::TRAP_LEVEL[0], pri_pkg::TRAP_VEC[0]);
    wr(pri_pkg::ADR_CONTROL, 16'h0003);
    $display("test masking done");
    // timed disable lets level 7 through and holds level 4 back
    pulse(8'h01, 2'b00);
    cpu_cmd(1'b0, 4'h0, 1'b1);
    cpu_cmd(1'b1, 4'h0, 1'b0);
    req_is(1'b1, 4'h7, pri_pkg::SRC_VEC[6]);
    wr(pri_pkg::ADR_FLAG, 16'h0040);
    req_is(1'b0, 4'h0, 7'h00);
    cyc(40);
    req_is(1'b1, 4'h4, pri_pkg::SRC_VEC[0]);
    wr(pri_pkg::ADR_FLAG, 16'h00ff);
    $display("test timed disable done");
    // nesting disable holds a higher user source back in a routine, a trap passes
    wr(pri_pkg::ADR_CONTROL, 16'h8000);
    auto <= 1'b1;
    pulse(8'h01, 2'b00);
    wait_level(4'h4);
    pulse(8'h40, 2'b00);
    req_is(1'b0, 4'h0, 7'h00);
    pulse(8'h00, 2'b10);
    req_is(1'b1, pri_pkg::TRAP_LEVEL[1], pri_pkg::TRAP_VEC[1]);
    wr(pri_pkg::ADR_FLAG, 16'h00ff);
    wr(pri_pkg::ADR_CONTROL, 16'h0003);
    auto <= 1'b0;
    wait_level(4'h0);
    $display("test nesting done");
    // clock enable low freezes all state, so an event in that time is lost
    ce <= 1'b0;
    pulse(8'h01, 2'b00);
    ce <= 1'b1;
    req_is(1'b0, 4'h0, 7'h00);
    $display("test clock enable done");
    report_and_stop();
  end
endmodule // pri_controller_bench
`default_nettype wire
